// ==== ccrsd_core_dec.sv ====
// Purpose: Core to platform ratio decoder, in half steps
// Assumes: Same encoding for both cores
// Notes: Reserved codes give zero and a flag
`timescale 1ns/10ps
`default_nettype none

module ccrsd_core_dec (
  // Strap code
  input wire logic [2:0] code,
  // Decoded ratio
  output logic [3:0] half,
  output logic rsvd
);

  // ==========================================================
  // Decode
  always_comb begin
    rsvd = 1'b0;
    unique case (code)
      3'h0, 3'h1, 3'h2: begin
        half = 4'h0;
        rsvd = 1'b1;
      end
      3'h3: half = 4'h3;
      3'h4: half = 4'h4;
      3'h5: half = 4'h5;
      3'h6: half = 4'h6;
      3'h7: half = 4'h7;
    endcase
  end

endmodule

`default_nettype wire

// ==== ccrsd_defines.svh ====
// Purpose: Offsets, field positions, reset values and counts
// Assumes: APB, 32-bit data, one word per register
// Notes: Definitions only
`ifndef CCRSD_DEFINES_SVH
`define CCRSD_DEFINES_SVH

// ==========================================================
// Register offsets
`define CCRSD_RAW_OFS 12'h000
`define CCRSD_RATIO_OFS 12'h004
`define CCRSD_STATUS_OFS 12'h008
`define CCRSD_CTRL_OFS 12'h00c

// ==========================================================
// Field positions
`define CCRSD_RAW_PLAT 0
`define CCRSD_RAW_CORE0 4
`define CCRSD_RAW_CORE1 8
`define CCRSD_RAW_MEM 12
`define CCRSD_RAT_PLAT 0
`define CCRSD_RAT_CORE0 4
`define CCRSD_RAT_CORE1 8
`define CCRSD_RAT_MEM 12
`define CCRSD_RAT_SYNC 16
`define CCRSD_ST_CAPT 0
`define CCRSD_ST_PRSV 1
`define CCRSD_ST_C0RSV 2
`define CCRSD_ST_C1RSV 3
`define CCRSD_ST_REFNEED 4
`define CCRSD_CTRL_MCLKEN 0

// ==========================================================
// Reset values and timing
`define CCRSD_CTRL_RST 1'h1
`define CCRSD_SETTLE_CYC 2'h3

`endif

// ==== ccrsd_pkg.sv ====
// Purpose: Types shared by the strap decoder files
// Assumes: Nothing beyond the defines header
// Notes: Ratios kept as integer numerators, cores in halves
package ccrsd_pkg;

  // ==========================================================
  // Decoded selections
  typedef struct packed {
    logic [3:0] plat_num;
    logic [3:0] core0_half;
    logic [3:0] core1_half;
    logic [3:0] mem_num;
    logic mem_sync;
  } ccrsd_ratio_t;

  // ==========================================================
  // Capture sequencer
  typedef enum logic [0:0] {
    CCRSD_WAIT,
    CCRSD_HELD
  } ccrsd_state_t;

endpackage

// ==== ccrsd_strap_board.sv ====
// Purpose: Board strap resistors behind the shared config pins
// Assumes: Straps are static, set before reset is released
// Notes: Reserved platform code only when the bench allows it
`timescale 1ns/10ps
`default_nettype none

module ccrsd_strap_board (
  // Codes wanted by the bench
  input wire logic [2:0] plat_code,
  input wire logic [2:0] core0_code,
  input wire logic [2:0] core1_code,
  input wire logic [2:0] mem_code,
  input wire logic allow_rsvd,
  // Resistor levels on the pins
  output logic [2:0] plat_pins,
  output logic [2:0] core0_pins,
  output logic [2:0] core1_pins,
  output logic [2:0] mem_pins
);
  // ==========================================================
  // Strap levels
  // No default ratio exists, so a reserved code is refused here
  assign plat_pins = (plat_code[2:1] == 2'h3 && !allow_rsvd) ?
    3'h0 : plat_code;
  // Bench picks codes within rate and speed limits
  assign mem_pins = mem_code;
  assign core0_pins = core0_code;
  assign core1_pins = core1_code;
endmodule
`default_nettype wire

// ==== ccrsd_strap_sync.sv ====
// Purpose: Two-stage synchroniser for one 3-bit strap group
// Assumes: Straps are static pins during power-on reset
// Notes: First stage feeds only the second
`timescale 1ns/10ps
`default_nettype none

module ccrsd_strap_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins and synchronised value
  input wire logic [2:0] pin,
  output logic [2:0] sync_q
);

  logic [2:0] meta_reg;

  // ==========================================================
  // Per-bit synchroniser
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_reg[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_reg[i] <= pin[i];
          sync_q[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ==== ccrsd_top.sv ====
// Purpose: Strap capture and clock ratio decode with APB view
// Assumes: pclk is the platform bus clock, 125 MHz
// Notes: Selections are frozen until the next reset
`timescale 1ns/10ps
`include "ccrsd_defines.svh"
`default_nettype none

module ccrsd_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Strap pins
  input wire logic [2:0] platform_ratio_straps,
  input wire logic core0_ratio_strap_msb,
  input wire logic core0_ratio_strap_mid,
  input wire logic core0_ratio_strap_lsb,
  input wire logic core1_ratio_strap_msb,
  input wire logic core1_ratio_strap_mid,
  input wire logic core1_ratio_strap_lsb,
  input wire logic mem_ratio_strap_msb,
  input wire logic mem_ratio_strap_mid,
  input wire logic mem_ratio_strap_lsb,
  // Selections to the clock generators
  output ccrsd_pkg::ccrsd_ratio_t ratio_sel,
  output logic straps_captured,
  output logic plat_code_rsvd,
  output logic core0_code_rsvd,
  output logic core1_code_rsvd,
  output logic mem_ref_clk_needed,
  output logic [1:0] mem_ctrl_sync,
  output logic mem_ctrl_clk_from_pll,
  output logic memory_bus_clock_out
);

  logic [2:0] plat_s;
  logic [2:0] core0_s;
  logic [2:0] core1_s;
  logic [2:0] mem_s;
  logic [3:0] core0_half;
  logic [3:0] core1_half;
  logic core0_rsvd;
  logic core1_rsvd;
  logic [3:0] plat_num;
  logic plat_rsvd;
  logic [3:0] mem_num;
  logic mem_sync;
  logic [14:0] raw_reg;
  logic [1:0] cnt_reg;
  logic capture;
  logic rel_reg;
  logic mclk_en_reg;
  logic mclk_reg;
  logic [31:0] rdata_next;
  logic err_next;
  logic setup;
  logic wr_acc;
  ccrsd_pkg::ccrsd_state_t state_reg;

  // ==========================================================
  // Pin synchronisers
  ccrsd_strap_sync u_sync_plat (.pclk(pclk), .presetn(presetn),
    .pin(platform_ratio_straps), .sync_q(plat_s));

  ccrsd_strap_sync u_sync_core0 (.pclk(pclk), .presetn(presetn),
    .pin({core0_ratio_strap_msb, core0_ratio_strap_mid,
          core0_ratio_strap_lsb}), .sync_q(core0_s));

  ccrsd_strap_sync u_sync_core1 (.pclk(pclk), .presetn(presetn),
    .pin({core1_ratio_strap_msb, core1_ratio_strap_mid,
          core1_ratio_strap_lsb}), .sync_q(core1_s));

  ccrsd_strap_sync u_sync_mem (.pclk(pclk), .presetn(presetn),
    .pin({mem_ratio_strap_msb, mem_ratio_strap_mid,
          mem_ratio_strap_lsb}), .sync_q(mem_s));

  // ==========================================================
  // Decoders
  // Separate instances keep the two cores independent
  ccrsd_core_dec u_dec_core0 (
    .code(core0_s), .half(core0_half), .rsvd(core0_rsvd));

  ccrsd_core_dec u_dec_core1 (
    .code(core1_s), .half(core1_half), .rsvd(core1_rsvd));

  // No default ratio exists, so reserved codes give zero and raise a flag
  always_comb begin
    plat_rsvd = 1'b0;
    unique case (plat_s)
      3'h0: plat_num = 4'h4;
      3'h1: plat_num = 4'h5;
      3'h2: plat_num = 4'h6;
      3'h3: plat_num = 4'h8;
      3'h4: plat_num = 4'ha;
      3'h5: plat_num = 4'hc;
      3'h6, 3'h7: begin
        plat_num = 4'h0;
        plat_rsvd = 1'b1;
      end
    endcase
  end

  always_comb begin
    mem_sync = 1'b0;
    unique case (mem_s)
      3'h0: mem_num = 4'h3;
      3'h1: mem_num = 4'h4;
      3'h2: mem_num = 4'h6;
      3'h3: mem_num = 4'h8;
      3'h4: mem_num = 4'ha;
      3'h5: mem_num = 4'hc;
      3'h6: mem_num = 4'he;
      3'h7: begin
        mem_num = 4'h0;
        mem_sync = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // Capture sequencer
  // Waits out the synchroniser so no pre-reset value is taken
  assign capture = (state_reg == ccrsd_pkg::CCRSD_WAIT) &&
                   (cnt_reg == `CCRSD_SETTLE_CYC - 2'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ccrsd_pkg::CCRSD_WAIT;
      cnt_reg <= 2'h0;
    end else begin
      unique case (state_reg)
        ccrsd_pkg::CCRSD_WAIT: begin
          cnt_reg <= cnt_reg + 2'h1;
          if (capture) begin
            state_reg <= ccrsd_pkg::CCRSD_HELD;
          end
        end
        ccrsd_pkg::CCRSD_HELD: begin
          cnt_reg <= cnt_reg;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio_sel <= '0;
      raw_reg <= 15'h0000;
      plat_code_rsvd <= 1'b0;
      core0_code_rsvd <= 1'b0;
      core1_code_rsvd <= 1'b0;
      straps_captured <= 1'b0;
    end else if (capture) begin
      ratio_sel.plat_num <= plat_num;
      ratio_sel.core0_half <= core0_half;
      ratio_sel.core1_half <= core1_half;
      ratio_sel.mem_num <= mem_num;
      ratio_sel.mem_sync <= mem_sync;
      raw_reg <= {mem_s, 1'b0, core1_s, 1'b0, core0_s, 1'b0, plat_s};
      plat_code_rsvd <= plat_rsvd;
      core0_code_rsvd <= core0_rsvd;
      core1_code_rsvd <= core1_rsvd;
      straps_captured <= 1'b1;
    end
  end

  // ==========================================================
  // Memory clocking selections
  // Mixed modes are impossible: one bit drives both controllers
  assign mem_ctrl_sync = {2{ratio_sel.mem_sync}};
  assign mem_ctrl_clk_from_pll = straps_captured &&
                                 !ratio_sel.mem_sync;
  assign mem_ref_clk_needed = straps_captured &&
                              !ratio_sel.mem_sync;

  // Synchronous bus clock toggles every platform edge: half rate
  // Asynchronous bus clock comes from the memory PLL path instead
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclk_reg <= 1'b0;
    end else if (ratio_sel.mem_sync && mclk_en_reg) begin
      mclk_reg <= !mclk_reg;
    end else begin
      mclk_reg <= 1'b0;
    end
  end

  assign memory_bus_clock_out = mclk_reg;

  // ==========================================================
  // APB slave
  // Zero wait states; read data is prepared in the setup cycle
  assign pready = 1'b1;
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;

  always_comb begin
    rdata_next = 32'h00000000;
    err_next = 1'b0;
    unique case (paddr)
      `CCRSD_RAW_OFS: begin
        rdata_next[14:0] = raw_reg;
        err_next = pwrite;
      end
      `CCRSD_RATIO_OFS: begin
        rdata_next[`CCRSD_RAT_PLAT +: 4] = ratio_sel.plat_num;
        rdata_next[`CCRSD_RAT_CORE0 +: 4] = ratio_sel.core0_half;
        rdata_next[`CCRSD_RAT_CORE1 +: 4] = ratio_sel.core1_half;
        rdata_next[`CCRSD_RAT_MEM +: 4] = ratio_sel.mem_num;
        rdata_next[`CCRSD_RAT_SYNC] = ratio_sel.mem_sync;
        err_next = pwrite;
      end
      `CCRSD_STATUS_OFS: begin
        rdata_next[`CCRSD_ST_CAPT] = straps_captured;
        rdata_next[`CCRSD_ST_PRSV] = plat_code_rsvd;
        rdata_next[`CCRSD_ST_C0RSV] = core0_code_rsvd;
        rdata_next[`CCRSD_ST_C1RSV] = core1_code_rsvd;
        rdata_next[`CCRSD_ST_REFNEED] = mem_ref_clk_needed;
        err_next = pwrite;
      end
      `CCRSD_CTRL_OFS: begin
        rdata_next[`CCRSD_CTRL_MCLKEN] = mclk_en_reg;
      end
      default: begin
        err_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h00000000 : rdata_next;
      pslverr <= err_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclk_en_reg <= `CCRSD_CTRL_RST;
    end else if (wr_acc && (paddr == `CCRSD_CTRL_OFS) && pstrb[0]) begin
      mclk_en_reg <= pwdata[`CCRSD_CTRL_MCLKEN];
    end
  end

  // ==========================================================
  // Checks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_reg <= 1'b0;
    end else begin
      rel_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Edge 1 after release is the first run edge; rel_reg rises there
  sequence s_settle;
    !straps_captured [*2];
  endsequence

  sequence s_held;
    straps_captured ##1 straps_captured;
  endsequence

  capture_time_a: assert property (
    $rose(rel_reg) |-> s_settle ##1 straps_captured)
    else $error("straps not captured at settle count");
  hold_ratio_a: assert property (
    s_held |-> $stable(ratio_sel) && $stable(raw_reg))
    else $error("ratio changed after capture");
  plat_decode_a: assert property (
    $rose(straps_captured) && raw_reg[2:0] == 3'h3
    |-> ratio_sel.plat_num == 4'h8)
    else $error("platform code 011 not 8:1");
  core0_decode_a: assert property (
    $rose(straps_captured) && raw_reg[6:4] == 3'h5
    |-> ratio_sel.core0_half == 4'h5)
    else $error("core0 code 101 not 5:2");
  core1_decode_a: assert property (
    $rose(straps_captured) && raw_reg[10:8] == 3'h7
    |-> ratio_sel.core1_half == 4'h7)
    else $error("core1 code 111 not 7:2");
  mem_decode_a: assert property (
    $rose(straps_captured) && raw_reg[14:12] == 3'h6
    |-> ratio_sel.mem_num == 4'he && !ratio_sel.mem_sync)
    else $error("memory code 110 not 14:1");
  sync_half_a: assert property (
    ratio_sel.mem_sync && mclk_en_reg ##1 ratio_sel.mem_sync
    |-> memory_bus_clock_out != $past(memory_bus_clock_out))
    else $error("sync bus clock not half rate");
  ref_need_a: assert property (
    straps_captured |-> mem_ref_clk_needed == !mem_ctrl_sync[0]
    && mem_ctrl_clk_from_pll == mem_ref_clk_needed)
    else $error("reference need wrong for mode");
  same_mode_a: assert property (
    mem_ctrl_sync[0] == mem_ctrl_sync[1])
    else $error("controllers in mixed modes");

endmodule

`default_nettype wire

// ==== testbench.sv ====
// Purpose: Self-checking bench for the strap ratio decoder
// Assumes: APB with zero wait states, straps set before each reset release
// Notes: Every strap code is applied across eight resets
`timescale 1ns/10ps
`include "ccrsd_defines.svh"
`default_nettype none

module testbench;
  logic pclk, presetn, psel, penable, pwrite, allow, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, ep, e0, e1, em;
  logic pready, pslverr, capt, prsv, c0rsv, c1rsv, es, mb0;
  logic refn, fpll, mbclk;
  logic [1:0] msync;
  logic [2:0] pc, c0c, c1c, mc, pp, c0p, c1p, mp;
  ccrsd_pkg::ccrsd_ratio_t rsel;
  int err_total, compares;
  int cyc = 0;
  logic [3:0] plat_tab [8] = '{4'h4, 4'h5, 4'h6, 4'h8, 4'ha, 4'hc,
    4'h0, 4'h0};
  logic [3:0] core_tab [8] = '{4'h0, 4'h0, 4'h0, 4'h3, 4'h4, 4'h5,
    4'h6, 4'h7};
  logic [3:0] mem_tab [8] = '{4'h3, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc,
    4'he, 4'h0};

  ccrsd_strap_board board_u (.plat_code(pc), .core0_code(c0c),
    .core1_code(c1c), .mem_code(mc), .allow_rsvd(allow),
    .plat_pins(pp), .core0_pins(c0p), .core1_pins(c1p),
    .mem_pins(mp));

  ccrsd_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .platform_ratio_straps(pp), .core0_ratio_strap_msb(c0p[2]),
    .core0_ratio_strap_mid(c0p[1]), .core0_ratio_strap_lsb(c0p[0]),
    .core1_ratio_strap_msb(c1p[2]), .core1_ratio_strap_mid(c1p[1]),
    .core1_ratio_strap_lsb(c1p[0]), .mem_ratio_strap_msb(mp[2]),
    .mem_ratio_strap_mid(mp[1]), .mem_ratio_strap_lsb(mp[0]),
    .ratio_sel(rsel), .straps_captured(capt),
    .plat_code_rsvd(prsv), .core0_code_rsvd(c0rsv),
    .core1_code_rsvd(c1rsv), .mem_ref_clk_needed(refn),
    .mem_ctrl_sync(msync), .mem_ctrl_clk_from_pll(fpll),
    .memory_bus_clock_out(mbclk));

  // ==========================================================
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Tasks
  task tally_and_finish;
    if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  // Caller enters just after a rising edge; one idle edge follows
  task apb(input logic [11:0] a, input logic w,
    input logic [31:0] d, input logic [3:0] s);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // ==========================================================
  // Sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, allow} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    {pc, c0c, c1c, mc} = 12'h0;
    err_total = 0;
    compares = 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      presetn <= 1'b0;
      pc <= 3'(i);
      c0c <= 3'(i);
      c1c <= 3'(7 - i);
      mc <= 3'(i);
      allow <= (i > 5);
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      ep = plat_tab[i];
      e0 = core_tab[i];
      e1 = core_tab[7 - i];
      em = mem_tab[i];
      es = (i == 7);
      repeat (6) @(posedge pclk);
      chk("captured", 32'h1, {31'h0, capt});
      // Later strap moves must not reach the selections
      pc <= 3'(7 - i);
      c0c <= 3'(7 - i);
      c1c <= 3'(i);
      mc <= 3'(7 - i);
      repeat (6) @(posedge pclk);
      chk("ratio_sel", {15'h0, ep, e0, e1, em, es}, {15'h0, rsel});
      chk("rsvd", {29'h0, ep == 0, e0 == 0, e1 == 0},
        {29'h0, prsv, c0rsv, c1rsv});
      chk("memmode", {28'h0, !es, !es, es, es},
        {28'h0, refn, fpll, msync});
      chk("ctrlpair", {31'h0, msync[0]}, {31'h0, msync[1]});
      chk("frompll", {31'h0, !es}, {31'h0, fpll});
      apb(`CCRSD_RATIO_OFS, 1'b0, 32'h0, 4'h0);
      chk("ratio", {15'h0, es, em, e1, e0, ep}, rd);
      apb(`CCRSD_RAW_OFS, 1'b0, 32'h0, 4'h0);
      chk("raw", {17'h0, 3'(i), 1'b0, 3'(7 - i), 1'b0, 3'(i), 1'b0,
        3'(i)}, rd);
      apb(`CCRSD_STATUS_OFS, 1'b0, 32'h0, 4'h0);
      chk("status", {27'h0, !es, e1 == 0, e0 == 0, ep == 0, 1'b1},
        rd);
      // Sampled at falling edges, away from the toggle
      @(negedge pclk);
      mb0 = mbclk;
      @(negedge pclk);
      chk("mbclk", {31'h0, es & ~mb0}, {31'h0, mbclk});
    end
    // Last reset is synchronous mode, so the bus clock runs
    apb(`CCRSD_CTRL_OFS, 1'b0, 32'h0, 4'h0);
    chk("ctrl_rst", 32'h1, rd);
    apb(`CCRSD_CTRL_OFS, 1'b1, 32'h0, 4'h1);
    chk("ctrl_err", 32'h0, {31'h0, err});
    repeat (2) @(posedge pclk);
    chk("mbclk_off", 32'h0, {31'h0, mbclk});
    apb(`CCRSD_CTRL_OFS, 1'b1, 32'h1, 4'h0);
    apb(`CCRSD_CTRL_OFS, 1'b0, 32'h0, 4'h0);
    chk("ctrl_strb", 32'h0, rd);
    apb(`CCRSD_RATIO_OFS, 1'b1, 32'hffff_ffff, 4'hf);
    chk("ro_err", 32'h1, {31'h0, err});
    apb(`CCRSD_RATIO_OFS, 1'b0, 32'h0, 4'h0);
    chk("ro_keep", {15'h0, 1'b1, 4'h0, 4'h0, 4'h7, 4'h0}, rd);
    apb(12'h010, 1'b0, 32'h0, 4'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("unmap_rd", 32'h0, rd);
    tally_and_finish();
  end
endmodule
`default_nettype wire
